// file: sim/brs_eeprom_model.sv
// behavioural two-wire eeprom slave: optional ack on the ninth clock
`timescale 1ns/1ps
module brs_eeprom_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic ack_en,
  output logic      sda_pull
);
  int unsigned nfall = 0;
  initial sda_pull = 1'b0;
  // start condition restarts the bit count
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      nfall = 0;
    end
  end
  // falls: 1 from start, 8 data bits, so the 9th low phase is the ack slot
  always @(negedge scl) begin
    nfall = nfall + 1;
    sda_pull = ack_en && (nfall == 9);
  end
endmodule

// file: sim/tb_top.sv
// testbench: register access and two recovery runs against the eeprom model
`timescale 1ns/1ps
module tb_top;
  import brs_pkg::*;
  logic              clk, rst, wr, rd, ack_en, sda_pull;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata, rdata;
  logic              scl_out, scl_oe, sda_out, sda_oe, pin_port_mode;
  logic              ctl_reset, ctl_halt, done, done_ack;
  logic              scl_q = 1'b1, sda_q = 1'b1, oe_q = 1'b0;
  logic [7:0]        bits;
  int                fails = 0, n_checks = 0, cyc = 0, bad = 0;
  int                rises = 0, starts = 0, stops = 0, resets = 0, hi = 0, hi_min = 0, hi_max = 0;
  // open-drain lines with pull-ups
  wire scl_w = (scl_oe && !scl_out) ? 1'b0 : 1'b1;
  wire sda_w = ((sda_oe && !sda_out) || sda_pull) ? 1'b0 : 1'b1;

  brs_sequencer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .pin_port_mode(pin_port_mode), .ctl_reset(ctl_reset),
    .ctl_halt(ctl_halt), .done(done), .done_ack(done_ack));
  brs_eeprom_model eeprom (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .sda_pull(sda_pull));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // wire monitor; also cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if ((scl_oe || sda_oe) && !pin_port_mode) bad++;
    if (scl_oe && !oe_q && !(scl_out && sda_out)) bad++;
    if (ctl_reset && starts != 0) bad++;
    resets += ctl_reset;
    if (scl_w && !scl_q) begin
      rises++;
      hi = 0;
      // stop clock rise also has data driven; only the eight data clocks count
      if (sda_oe && rises <= 8) bits = {bits[6:0], sda_w};
    end
    if (scl_w) hi++;
    if (!scl_w && scl_q && rises > 0) begin
      hi_min = (hi < hi_min) ? hi : hi_min;
      hi_max = (hi > hi_max) ? hi : hi_max;
    end
    if (scl_w && scl_q && sda_q && !sda_w) starts++;
    if (scl_w && scl_q && !sda_q && sda_w) stops++;
    scl_q = scl_w;
    sda_q = sda_w;
    oe_q = scl_oe;
    if (cyc > 20000) begin
      fails++;
      wrap_up;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  // one recovery; second start and wait write land while busy and must be ignored
  task automatic run(input logic [15:0] w, input logic [7:0] b, input logic a);
    int n;
    wr_reg(REG_WAIT, {16'h0000, w});
    wr_reg(REG_DUMMY, {24'h000000, b});
    @(posedge clk);
    ack_en <= a;
    #1;
    rises = 0;
    starts = 0;
    stops = 0;
    resets = 0;
    hi_min = 1000;
    hi_max = 0;
    wr_reg(REG_CTRL, 32'h0000_0001);
    wr_reg(REG_CTRL, 32'h0000_0001);
    wr_reg(REG_WAIT, 32'h0000_0007);
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done", 1, done);
    chk("done_ack", !a, done_ack);
    chk("dummy bits", b, bits);
    chk("clock rises", 10, rises);
    chk("starts", 1, starts);
    chk("stops", 1, stops);
    chk("ctl resets", 1, resets);
    chk("ctl halt", 1, ctl_halt);
    chk("high even", hi_min, hi_max);
    chk("high time", 1, hi_min >= w + 1 && hi_min <= w + 3);
    chk("order faults", 0, bad);
    rd_chk("levels", REG_LEVELS, {16'h0000, LEVELS_RECOVERY});
    rd_chk("status", REG_STATUS, {28'h0000000, 1'b1, 1'b1, !a, 1'b0});
    rd_chk("wait kept", REG_WAIT, {16'h0000, w});
  endtask

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    ack_en = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk("pins released", 0, {scl_oe, sda_oe});
    rd_chk("wait reset", REG_WAIT, {16'h0000, WAIT_RESET});
    rd_chk("dummy reset", REG_DUMMY, {24'h000000, DUMMY_RESET});
    wr_reg(REG_LEVELS, 32'h0000_FFFF);
    rd_chk("levels reset", REG_LEVELS, {16'h0000, LEVELS_RESET});
    // clock pin idles high and ack level resets to no-ack
    rd_chk("status reset", REG_STATUS, 32'h0000_000A);
    rd_chk("unmapped", 4'h6, 32'h0000_0000);
    run(16'h0003, 8'hA5, 1'b1);
    run(16'h0001, 8'h01, 1'b0);
    wrap_up;
  end
endmodule

// file: src/brs_pkg.sv
// package: constants and types for the bus-recovery sequencer
package brs_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_WAIT        = 4'h4;
  localparam logic [3:0]  REG_DUMMY       = 4'h8;
  localparam logic [3:0]  REG_STATUS      = 4'hC;
  localparam logic [3:0]  REG_LEVELS      = 4'h2;
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_ACK_BIT    = 1;
  localparam int unsigned STAT_CTL_BIT    = 2;
  localparam int unsigned DATA_LEVEL_BIT  = 3;
  localparam int unsigned CLOCK_LEVEL_BIT = 2;
  localparam logic [15:0] LEVELS_RECOVERY = 16'h000C;
  localparam logic [15:0] LEVELS_RESET    = 16'h0000;
  localparam logic [15:0] WAIT_RESET      = 16'h0032;
  localparam logic [7:0]  DUMMY_RESET     = 8'hFF;
  localparam logic [3:0]  BYTE_BITS       = 4'h8;

  typedef enum logic [1:0] {
    brs_ph_low_type_lo,
    brs_ph_high_type_hi,
    brs_ph_end_type_end
  } brs_phase_type;

  typedef enum {
    ST_IDLE, ST_PRESET, ST_DIR, ST_CTL_RESET,
    ST_START_HI, ST_START_SDA, ST_START_LOW, ST_WAIT1,
    ST_BIT_LOW, ST_BIT_HIGH, ST_BIT_END,
    ST_ACK_LOW, ST_ACK_HIGH, ST_ACK_END,
    ST_STOP_LOW, ST_STOP_SCL, ST_STOP_HIGH, ST_WAIT2, ST_DONE
  } brs_state_type;
endpackage

// file: src/brs_sequencer.sv
// bus-recovery sequencer: bit-bangs start, dummy byte, ack clock, stop
`timescale 1ns/1ps
module brs_sequencer
  import brs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata,
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  output logic                   pin_port_mode,
  output logic                   ctl_reset,
  output logic                   ctl_halt,
  output logic                   done,
  output logic                   done_ack
);
  brs_state_type state;
  logic [15:0]   wait_cnt;
  logic [7:0]    dummy;
  logic [15:0]   port_b_low_levels;
  logic [3:0]    bit_cnt;
  logic [7:0]    shift;
  logic          ack_level;
  logic          sda_meta;
  logic          sda_sync;
  logic          scl_meta;
  logic          scl_sync;
  logic          wait_start;
  logic          wait_done;
  logic          data_dir_out;
  logic          busy;

  function automatic logic [15:0] level_word(input logic scl, input logic sda);
    logic [15:0] w;
    w = LEVELS_RESET;
    if (sda) begin
      w[DATA_LEVEL_BIT] = 1'b1;
    end
    if (scl) begin
      w[CLOCK_LEVEL_BIT] = 1'b1;
    end
    return w;
  endfunction

  brs_wait_timer u_wait (
    .clk      (clk),
    .rst      (rst),
    .start    (wait_start),
    .wait_cnt (wait_cnt),
    .done     (wait_done)
  );

  // pin inputs come from outside, two flops first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
    end else begin
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
    end
  end

  // register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= WAIT_RESET;
      dummy    <= DUMMY_RESET;
    end else if (wr && !busy) begin
      if (addr == REG_WAIT) begin
        wait_cnt <= wdata[15:0];
      end
      if (addr == REG_DUMMY) begin
        dummy <= wdata[7:0];
      end
    end
  end

  assign busy = (state != ST_IDLE);

  // sequencer; wait_start fires on entering each waited step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state             <= ST_IDLE;
      port_b_low_levels <= LEVELS_RESET;
      data_dir_out      <= 1'b0;
      scl_oe            <= 1'b0;
      pin_port_mode     <= 1'b0;
      ctl_reset         <= 1'b0;
      ctl_halt          <= 1'b0;
      bit_cnt           <= 4'h0;
      shift             <= 8'h00;
      ack_level         <= 1'b1;
      wait_start        <= 1'b0;
      done              <= 1'b0;
      done_ack          <= 1'b0;
    end else begin
      wait_start <= 1'b0;
      done       <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (wr && addr == REG_CTRL && wdata[CTRL_START_BIT]) begin
            pin_port_mode <= 1'b1;
            state         <= ST_PRESET;
          end
        end
        ST_PRESET: begin
          port_b_low_levels <= LEVELS_RECOVERY;
          state             <= ST_DIR;
        end
        ST_DIR: begin
          data_dir_out <= 1'b1;
          scl_oe       <= 1'b1;
          ctl_reset    <= 1'b1;
          ctl_halt     <= 1'b1;
          state        <= ST_CTL_RESET;
        end
        ST_CTL_RESET: begin
          ctl_reset <= 1'b0;
          state     <= ST_START_HI;
        end
        ST_START_HI: begin
          port_b_low_levels <= level_word(1'b1, 1'b1);
          state             <= ST_START_SDA;
        end
        ST_START_SDA: begin
          port_b_low_levels <= level_word(1'b1, 1'b0);
          state             <= ST_START_LOW;
        end
        ST_START_LOW: begin
          port_b_low_levels <= level_word(1'b0, 1'b0);
          wait_start        <= 1'b1;
          state             <= ST_WAIT1;
        end
        ST_WAIT1: begin
          if (wait_done) begin
            bit_cnt           <= BYTE_BITS;
            shift             <= dummy;
            port_b_low_levels <= level_word(1'b0, dummy[7]);
            wait_start        <= 1'b1;
            state             <= ST_BIT_LOW;
          end
        end
        ST_BIT_LOW: begin
          if (wait_done) begin
            port_b_low_levels <= level_word(1'b1, shift[7]);
            wait_start        <= 1'b1;
            state             <= ST_BIT_HIGH;
          end
        end
        ST_BIT_HIGH: begin
          if (wait_done) begin
            port_b_low_levels <= level_word(1'b0, shift[7]);
            wait_start        <= 1'b1;
            bit_cnt           <= bit_cnt - 4'h1;
            state             <= ST_BIT_END;
          end
        end
        ST_BIT_END: begin
          if (wait_done) begin
            if (bit_cnt != 4'h0) begin
              port_b_low_levels <= level_word(1'b0, shift[6]);
              shift             <= {shift[6:0], 1'b0};
              state             <= ST_BIT_LOW;
            end else begin
              data_dir_out      <= 1'b0;
              port_b_low_levels <= level_word(1'b0, 1'b0);
              state             <= ST_ACK_LOW;
            end
            wait_start <= 1'b1;
          end
        end
        ST_ACK_LOW: begin
          if (wait_done) begin
            port_b_low_levels <= level_word(1'b1, 1'b0);
            wait_start        <= 1'b1;
            state             <= ST_ACK_HIGH;
          end
        end
        ST_ACK_HIGH: begin
          if (wait_done) begin
            ack_level         <= sda_sync;
            port_b_low_levels <= level_word(1'b0, 1'b0);
            wait_start        <= 1'b1;
            state             <= ST_ACK_END;
          end
        end
        ST_ACK_END: begin
          if (wait_done) begin
            data_dir_out      <= 1'b1;
            port_b_low_levels <= level_word(1'b0, 1'b0);
            state             <= ST_STOP_LOW;
          end
        end
        ST_STOP_LOW: begin
          port_b_low_levels <= level_word(1'b1, 1'b0);
          state             <= ST_STOP_SCL;
        end
        ST_STOP_SCL: begin
          port_b_low_levels <= level_word(1'b1, 1'b1);
          state             <= ST_STOP_HIGH;
        end
        ST_STOP_HIGH: begin
          wait_start <= 1'b1;
          state      <= ST_WAIT2;
        end
        ST_WAIT2: begin
          if (wait_done) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          // pins stay as port outputs high; controller remains halted
          done     <= 1'b1;
          done_ack <= ack_level;
          state    <= ST_IDLE;
        end
      endcase
    end
  end

  // pin drivers straight from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_out <= 1'b1;
      sda_out <= 1'b1;
      sda_oe  <= 1'b0;
    end else begin
      scl_out <= port_b_low_levels[CLOCK_LEVEL_BIT];
      sda_out <= port_b_low_levels[DATA_LEVEL_BIT];
      sda_oe  <= data_dir_out;
    end
  end

  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= 32'h00000000;
      if (rd) begin
        unique case (addr)
          REG_WAIT:   rdata <= {16'h0000, wait_cnt};
          REG_DUMMY:  rdata <= {24'h000000, dummy};
          REG_LEVELS: rdata <= {16'h0000, port_b_low_levels};
          REG_STATUS: rdata <= {28'h0000000, scl_sync, ctl_halt, ack_level, busy};
          default:    rdata <= 32'h00000000;
        endcase
      end
    end
  end

  a_start_order: assert property (@(posedge clk) disable iff (rst)
    state == ST_START_SDA |=> port_b_low_levels == 16'h0004)
    else $error("start: clock high, data low missing");

  // clock enable rises once only; data enable rises again before stop with data low
  a_preset_first: assert property (@(posedge clk) disable iff (rst)
    $rose(scl_oe) |-> sda_out && scl_out)
    else $error("pins enabled before preset high");

  a_reset_pulse: assert property (@(posedge clk) disable iff (rst)
    $rose(ctl_reset) |-> ctl_halt ##1 !ctl_reset)
    else $error("controller reset not one cycle with halt");

  a_level_mask: assert property (@(posedge clk) disable iff (rst)
    (port_b_low_levels & 16'hFFF3) == 16'h0000)
    else $error("unused level bits set");

  sequence s_bit_high;
    state == ST_BIT_LOW && wait_done ##1 port_b_low_levels[CLOCK_LEVEL_BIT];
  endsequence
  a_bit_clock: assert property (@(posedge clk) disable iff (rst)
    s_bit_high |-> $stable(port_b_low_levels[DATA_LEVEL_BIT]))
    else $error("data moved while clock rose");

  a_ack_release: assert property (@(posedge clk) disable iff (rst)
    state == ST_ACK_HIGH |-> !data_dir_out)
    else $error("data driven during acknowledge clock");

  a_stop_end: assert property (@(posedge clk) disable iff (rst)
    state == ST_STOP_SCL |=> port_b_low_levels == LEVELS_RECOVERY)
    else $error("stop did not end both high");

  a_done_ack: assert property (@(posedge clk) disable iff (rst)
    state == ST_DONE |=> done && done_ack == $past(ack_level))
    else $error("done pulse wrong");

  a_byte_count: assert property (@(posedge clk) disable iff (rst)
    state == ST_ACK_LOW |-> bit_cnt == 4'h0)
    else $error("ack before all bits sent");

  // start is taken one edge late, then one count and the done flop
  a_wait_bound: assert property (@(posedge clk) disable iff (rst)
    wait_start && wait_cnt == 16'h0001 |-> ##2 wait_done)
    else $error("wait length wrong");
endmodule

// file: src/brs_wait_timer.sv
// half-bus-period wait counter, one-cycle done pulse
`timescale 1ns/1ps
module brs_wait_timer
  import brs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] wait_cnt,
  output logic             done
);
  logic [15:0] cnt;
  logic        running;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= 16'h0000;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt     <= 16'h0000;
        running <= 1'b1;
      end else if (running) begin
        // counts up to the programmed length, zero still gives one cycle
        if (cnt + 16'h0001 >= wait_cnt) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  end
endmodule
